// file: logic/placeholder_none.sv
// intentionally empty compile unit
`default_nettype none
`default_nettype wire

// file: logic/rrc_lsw.sv
// one load-switch controller: gate drive divider and soft-start period count
`default_nettype none
module rrc_lsw #(
	parameter int PERIODS = rrc_pkg::SW_SS_PERIODS
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_osc_rise,
	input  wire logic       i_en,
	input  wire logic [2:0] i_freq,
	output logic            o_gate,
	output logic            o_done
);
	import rrc_pkg::*;
	logic [6:0] div_ff;
	logic [8:0] per_ff;
	logic       gate_ff;
	logic       done_ff;
	logic [6:0] div_top;
	logic       tick;
	logic [6:0] nxt_div;
	logic [8:0] nxt_per;
	logic       nxt_gate;
	// ---------------------------------------------
	// drive oscillator: base rate divided by 2^freq
	// ---------------------------------------------
	assign div_top  = 7'((8'h01 << i_freq) - 8'h01);
	assign tick     = i_en && i_osc_rise && (div_ff == div_top);
	assign nxt_div  = !i_en ? 7'h00 : (tick ? 7'h00 : (i_osc_rise ? div_ff + 7'h01 : div_ff));
	assign nxt_per  = !i_en ? 9'h000 : ((tick && !done_ff) ? per_ff + 9'h001 : per_ff);
	// gate toggles during soft-start, then holds fully on
	assign nxt_gate = !i_en ? 1'b0 : (done_ff ? 1'b1 : (tick ? ~gate_ff : gate_ff));
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			div_ff  <= 7'h00;
			per_ff  <= 9'h000;
			gate_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			div_ff  <= nxt_div;
			per_ff  <= nxt_per;
			gate_ff <= nxt_gate;
			done_ff <= i_en && (nxt_per == 9'(PERIODS));
		end
	end
	assign o_gate = gate_ff;
	assign o_done = done_ff;
	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	chk_done_periods: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$rose(done_ff) |-> per_ff == 9'(PERIODS))
		else $error("switch done without full period count");
	chk_gate_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_en |=> !gate_ff && !done_ff)
		else $error("switch gate active while disabled");
endmodule
`default_nettype wire

// file: logic/rrc_top.sv
// regulator rail control: 3A buck, linear regulator and three load switches
`default_nettype none
// Function
// - buck code field 0x37 gives 0.8V
// - buck code linear, 10mV per step
// - disabled buck discharges unless discharge disabled
// - undervoltage sets buck undervoltage flag
// - unmasked undervoltage requests power-down
// - undervoltage suppressed until soft-start ends
// - rising target ramp suppresses undervoltage
// - overvoltage sets buck overvoltage flag
// - unmasked overvoltage requests power-down
// - falling ramp enabled suppresses overvoltage
// - no falling ramp: overvoltage may trip
// - status shows live comparator levels
// - enable by sequencer or register write
// - mode code zero disables buck
// - low power by sleep or command
// - inrush block becomes third switch
// - switch input internal buck or system
// - gate drive oscillator from frequency field
// - soft-start done after 256 periods
// - linear code 0.8V up, 25mV steps
// - lockout with discharge enabled disables linear, discharge on
// - linear mode zero off; sequencer or write
// - slave only, never stalls the master
module rrc_top #(
	parameter int SS_CYC = rrc_pkg::BUCK_SS_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [4:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	input  wire logic        i_uv_cmp,
	input  wire logic        i_ov_cmp,
	input  wire logic        i_sys_uvlo,
	input  wire logic        i_drv_osc,
	input  wire logic        i_seq_buck_en,
	input  wire logic        i_seq_lin_en,
	input  wire logic [2:0]  i_seq_sw_en,
	input  wire logic        i_dev_sleep,
	input  wire logic        i_inrush_drive,
	output logic      [6:0]  o_buck_c_code,
	output logic      [10:0] o_buck_c_mv,
	output logic             o_buck_c_en,
	output logic             o_buck_c_lowpower,
	output logic             o_buck_c_discharge,
	output logic             o_power_down_req,
	output logic      [11:0] o_lin_mv,
	output logic             o_lin_en,
	output logic             o_lin_lowpower,
	output logic             o_lin_discharge,
	output logic      [2:0]  o_sw_gate,
	output logic      [2:0]  o_sw_done,
	output logic      [8:0]  o_sw_source,
	output logic             o_inrush_gate_drive_pin,
	output logic             o_inrush_pin_is_feedback
);
	import rrc_pkg::*;
	// ---------------------------------------------
	// decode helpers
	// ---------------------------------------------
	function automatic logic hit(input logic s, input logic [4:0] a, input logic [4:0] ofs);
		return s && (a == ofs);
	endfunction
	function automatic logic en_dec(input logic [7:0] fps, input logic [1:0] md, input logic seq);
		return (md != OPMD_OFF) && ((fps[7:6] == FPS_NONE) || seq);
	endfunction
	function automatic logic lp_dec(input logic [3:0] md, input logic slp);
		return (md[1:0] == OPMD_LP) || (slp && md[AUTO_LP_BIT]) || md[FORCE_LP_BIT];
	endfunction
	// ---------------------------------------------
	// registers and state
	// ---------------------------------------------
	logic [1:0]   uv_s_ff, ov_s_ff, uvlo_s_ff;
	logic [2:0]   osc_s_ff;
	logic [6:0]   vout_ff, cur_ff, lin_vout_ff;
	logic [1:0]   bcfg_ff, flag_ff, mask_ff;
	logic [3:0]   operating_mode_reg_one_ff, operating_mode_reg_two_ff;
	logic [7:0]   bfps_ff, lfps_ff;
	logic         ade_ff;
	logic [4:0]   inr_ff;
	rrc_sw_cfg_t  sw_cfg_ff [3];
	rrc_buck_st_t st_ff, nxt_st;
	logic [31:0]  ss_cnt_ff;
	logic [7:0]   step_ff;
	logic [1:0]   cond_ff;
	logic         pd_ff;
	logic [7:0]   rdata_ff;
	logic [6:0]   out_code_ff;
	logic [10:0]  buck_mv_ff;
	logic [11:0]  lin_mv_ff;
	logic         buck_en_ff, buck_lp_ff, buck_dis_ff;
	logic         lin_en_ff, lin_lp_ff, lin_dis_ff;
	logic [8:0]   src_ff;
	logic         inr_pin_ff, fb_sel_ff;
	// ---------------------------------------------
	// synchronisers and drive oscillator edge
	// ---------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			uv_s_ff   <= 2'h0;
			ov_s_ff   <= 2'h0;
			uvlo_s_ff <= 2'h0;
			osc_s_ff  <= 3'h0;
		end else begin
			uv_s_ff   <= {uv_s_ff[0], i_uv_cmp};
			ov_s_ff   <= {ov_s_ff[0], i_ov_cmp};
			uvlo_s_ff <= {uvlo_s_ff[0], i_sys_uvlo};
			osc_s_ff  <= {osc_s_ff[1:0], i_drv_osc};
		end
	end
	wire uv_live  = uv_s_ff[1];
	wire ov_live  = ov_s_ff[1];
	wire uvlo     = uvlo_s_ff[1];
	wire osc_rise = osc_s_ff[1] & ~osc_s_ff[2];
	// ---------------------------------------------
	// register writes
	// ---------------------------------------------
	wire       wr_int = hit(i_wr, i_addr, OFS_BUCK_INT);
	wire [1:0] clr    = wr_int ? i_wdata[1:0] : 2'h0;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			vout_ff     <= RST_BUCK_VOUT;
			bcfg_ff     <= 2'h0;
			mask_ff     <= RST_MASK;
			operating_mode_reg_one_ff    <= RST_OPMD;
			operating_mode_reg_two_ff    <= RST_OPMD;
			bfps_ff     <= RST_FPS;
			lfps_ff     <= RST_FPS;
			lin_vout_ff <= RST_LIN_VOUT;
			ade_ff      <= RST_LIN_ADE;
			inr_ff      <= 5'h00;
		end else begin
			if (hit(i_wr, i_addr, OFS_BUCK_VOUT)) vout_ff <= i_wdata[6:0];
			if (hit(i_wr, i_addr, OFS_BUCK_CFG)) bcfg_ff <= i_wdata[1:0];
			if (hit(i_wr, i_addr, OFS_BUCK_INTM)) mask_ff <= i_wdata[1:0];
			if (hit(i_wr, i_addr, OFS_OPMD_ONE)) operating_mode_reg_one_ff <= i_wdata[3:0];
			if (hit(i_wr, i_addr, OFS_OPMD_TWO)) operating_mode_reg_two_ff <= i_wdata[3:0];
			if (hit(i_wr, i_addr, OFS_BUCK_FPS)) bfps_ff <= i_wdata;
			if (hit(i_wr, i_addr, OFS_LIN_FPS)) lfps_ff <= i_wdata;
			if (hit(i_wr, i_addr, OFS_LIN_VOUT)) lin_vout_ff <= i_wdata[6:0];
			if (hit(i_wr, i_addr, OFS_LIN_CFG)) ade_ff <= i_wdata[0];
			if (hit(i_wr, i_addr, OFS_INRUSH)) inr_ff <= i_wdata[4:0];
		end
	end
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_cfg
			always_ff @(posedge i_clk) begin
				if (!i_rst_n) begin
					sw_cfg_ff[g] <= '0;
				end else if (hit(i_wr, i_addr, OFS_SW_CFG0 + 5'(g))) begin
					sw_cfg_ff[g] <= rrc_sw_cfg_t'(i_wdata[6:0]);
				end
			end
		end
	endgenerate
	// ---------------------------------------------
	// buck enable, mode and soft-start
	// ---------------------------------------------
	wire buck_en  = en_dec(bfps_ff, operating_mode_reg_one_ff[1:0], i_seq_buck_en);
	wire ss_last  = ss_cnt_ff == 32'(SS_CYC - 1);
	always_comb begin
		nxt_st = st_ff;
		case (st_ff)
			RRC_OFF: begin
				if (buck_en) nxt_st = RRC_SOFT;
			end
			RRC_SOFT: begin
				if (!buck_en) nxt_st = RRC_OFF;
				else if (ss_last) nxt_st = RRC_RUN;
			end
			RRC_RUN: begin
				if (!buck_en) nxt_st = RRC_OFF;
			end
			default: nxt_st = RRC_OFF;
		endcase
	end
	// ---------------------------------------------
	// controlled ramp of the applied code
	// ---------------------------------------------
	wire run      = st_ff == RRC_RUN;
	wire fsr      = bcfg_ff[FSR_BIT];
	wire ramp_up  = run && (cur_ff < vout_ff);
	wire ramp_dn  = run && (cur_ff > vout_ff) && fsr;
	wire ramping  = ramp_up || ramp_dn;
	wire step_end = step_ff == 8'(RAMP_CYC - 1);
	logic [6:0] nxt_cur;
	// without the falling ramp the target jumps and the output overshoots the new level
	assign nxt_cur = !run ? vout_ff :
		((cur_ff > vout_ff) && !fsr) ? vout_ff :
		(ramp_up && step_end) ? cur_ff + 7'h01 :
		(ramp_dn && step_end) ? cur_ff - 7'h01 : cur_ff;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st_ff     <= RRC_OFF;
			ss_cnt_ff <= 32'h0;
			cur_ff    <= RST_BUCK_VOUT;
			step_ff   <= 8'h00;
		end else begin
			st_ff     <= nxt_st;
			ss_cnt_ff <= (st_ff == RRC_SOFT) ? ss_cnt_ff + 32'h1 : 32'h0;
			cur_ff    <= nxt_cur;
			step_ff   <= (ramping && !step_end) ? step_ff + 8'h01 : 8'h00;
		end
	end
	// ---------------------------------------------
	// fault qualification, flags, power-down
	// ---------------------------------------------
	wire uv_ok   = run && !ramp_up;
	wire ov_ok   = run && !ramp_dn;
	wire [1:0] cond  = {ov_live & ov_ok, uv_live & uv_ok};
	wire [1:0] ev    = cond & ~cond_ff;
	wire [1:0] nxt_flag = (flag_ff & ~clr) | ev;
	wire nxt_pd  = |(ev & ~mask_ff);
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cond_ff <= 2'h0;
			flag_ff <= 2'h0;
			pd_ff   <= 1'b0;
		end else begin
			cond_ff <= cond;
			flag_ff <= nxt_flag;
			pd_ff   <= nxt_pd;
		end
	end
	// ---------------------------------------------
	// linear regulator
	// ---------------------------------------------
	wire lin_req = en_dec(lfps_ff, operating_mode_reg_two_ff[1:0], i_seq_lin_en);
	wire lin_en  = lin_req && !(uvlo && ade_ff);
	wire [11:0] lin_raw = LIN_BASE_MV + 12'(lin_vout_ff) * LIN_STEP_MV;
	// ---------------------------------------------
	// load switches
	// ---------------------------------------------
	wire third = inr_ff[INR_DIS_BIT] && inr_ff[THIRD_BIT];
	logic [2:0] sw_gate, sw_done;
	logic [8:0] nxt_src;
	generate
		for (g = 0; g < 3; g++) begin : g_sw
			wire sw_ok = (g < 2) || third;
			wire [2:0] freq = (g < 2) ? sw_cfg_ff[g].freq : inr_ff[INR_FREQ_LSB +: 3];
			assign nxt_src[3*g +: 3] = {sw_cfg_ff[g].ext, sw_cfg_ff[g].sel};
			rrc_lsw u_sw (
				.i_clk      (i_clk),
				.i_rst_n    (i_rst_n),
				.i_osc_rise (osc_rise),
				.i_en       ((sw_cfg_ff[g].enable | i_seq_sw_en[g]) & sw_ok),
				.i_freq     (freq),
				.o_gate     (sw_gate[g]),
				.o_done     (sw_done[g])
			);
		end
	endgenerate
	// ---------------------------------------------
	// read mux; slave answers every strobe one cycle later
	// ---------------------------------------------
	logic [7:0] rd_mux;
	always_comb begin
		case (i_addr)
			OFS_BUCK_VOUT: rd_mux = {1'b0, vout_ff};
			OFS_BUCK_CFG:  rd_mux = {6'h00, bcfg_ff};
			OFS_BUCK_INT:  rd_mux = {6'h00, flag_ff};
			OFS_BUCK_INTM: rd_mux = {6'h00, mask_ff};
			OFS_BUCK_STAT: rd_mux = {4'h0, ramping, run, ov_live, uv_live};
			OFS_OPMD_ONE:  rd_mux = {4'h0, operating_mode_reg_one_ff};
			OFS_OPMD_TWO:  rd_mux = {4'h0, operating_mode_reg_two_ff};
			OFS_BUCK_FPS:  rd_mux = bfps_ff;
			OFS_LIN_FPS:   rd_mux = lfps_ff;
			OFS_LIN_VOUT:  rd_mux = {1'b0, lin_vout_ff};
			OFS_LIN_CFG:   rd_mux = {7'h00, ade_ff};
			5'h0B:         rd_mux = {1'b0, sw_cfg_ff[0]};
			5'h0C:         rd_mux = {1'b0, sw_cfg_ff[1]};
			5'h0D:         rd_mux = {1'b0, sw_cfg_ff[2]};
			OFS_INRUSH:    rd_mux = {3'h0, inr_ff};
			OFS_SW_STAT:   rd_mux = {5'h00, sw_done[2:1] & {third, 1'b1}, sw_done[0]};
			default:       rd_mux = 8'h00;
		endcase
	end
	// ---------------------------------------------
	// registered outputs
	// ---------------------------------------------
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			rdata_ff    <= 8'h00;
			out_code_ff <= RST_BUCK_VOUT;
			buck_mv_ff  <= 11'h000;
			buck_en_ff  <= 1'b0;
			buck_lp_ff  <= 1'b0;
			buck_dis_ff <= 1'b0;
			lin_mv_ff   <= 12'h000;
			lin_en_ff   <= 1'b0;
			lin_lp_ff   <= 1'b0;
			lin_dis_ff  <= 1'b0;
			src_ff      <= 9'h000;
			inr_pin_ff  <= 1'b0;
			fb_sel_ff   <= 1'b0;
		end else begin
			rdata_ff    <= i_rd ? rd_mux : 8'h00;
			out_code_ff <= cur_ff;
			buck_mv_ff  <= BUCK_BASE_MV + 11'(cur_ff) * BUCK_STEP_MV;
			buck_en_ff  <= buck_en;
			buck_lp_ff  <= buck_en && lp_dec(operating_mode_reg_one_ff, i_dev_sleep);
			buck_dis_ff <= !buck_en && !bcfg_ff[DIS_BIT];
			lin_mv_ff   <= (lin_raw > LIN_MAX_MV) ? LIN_MAX_MV : lin_raw;
			lin_en_ff   <= lin_en;
			lin_lp_ff   <= lin_en && lp_dec(operating_mode_reg_two_ff, i_dev_sleep);
			lin_dis_ff  <= !lin_en && ade_ff;
			src_ff      <= nxt_src;
			inr_pin_ff  <= third ? sw_gate[2] : i_inrush_drive;
			fb_sel_ff   <= third;
		end
	end
	assign o_rdata                  = rdata_ff;
	assign o_buck_c_code            = out_code_ff;
	assign o_buck_c_mv              = buck_mv_ff;
	assign o_buck_c_en              = buck_en_ff;
	assign o_buck_c_lowpower        = buck_lp_ff;
	assign o_buck_c_discharge       = buck_dis_ff;
	assign o_power_down_req         = pd_ff;
	assign o_lin_mv                 = lin_mv_ff;
	assign o_lin_en                 = lin_en_ff;
	assign o_lin_lowpower           = lin_lp_ff;
	assign o_lin_discharge          = lin_dis_ff;
	assign o_sw_gate                = sw_gate;
	assign o_sw_done                = sw_done;
	assign o_sw_source              = src_ff;
	assign o_inrush_gate_drive_pin  = inr_pin_ff;
	assign o_inrush_pin_is_feedback = fb_sel_ff;
	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	chk_code_map: assert property (cur_ff == 7'h37 |=> buck_mv_ff == 11'h320)
		else $error("buck code 0x37 not 800 mV");
	chk_discharge: assert property (!buck_en && !bcfg_ff[DIS_BIT] |=> buck_dis_ff)
		else $error("disabled buck without discharge");
	chk_uv_flag: assert property (ev[UV_BIT] |=> flag_ff[UV_BIT])
		else $error("undervoltage flag not set");
	chk_uv_pd: assert property (ev[UV_BIT] && !mask_ff[UV_BIT] |=> pd_ff)
		else $error("unmasked undervoltage gave no request");
	chk_mask_quiet: assert property ((ev & ~mask_ff) == 2'h0 |=> !pd_ff)
		else $error("request raised while masked");
	chk_ss_block: assert property (st_ff != RRC_RUN |-> !cond[UV_BIT] && !cond[OV_BIT])
		else $error("fault seen during soft-start");
	chk_ramp_up: assert property (ramp_up |-> !ev[UV_BIT])
		else $error("undervoltage during rising ramp");
	chk_ov_flag: assert property (ev[OV_BIT] |=> flag_ff[OV_BIT])
		else $error("overvoltage flag not set");
	chk_ov_pd: assert property (ev[OV_BIT] && !mask_ff[OV_BIT] |=> pd_ff)
		else $error("unmasked overvoltage gave no request");
	chk_ramp_dn: assert property (ramp_dn |-> !ev[OV_BIT])
		else $error("overvoltage during falling ramp");
	chk_flag_hold: assert property (flag_ff[UV_BIT] && !clr[UV_BIT] |=> flag_ff[UV_BIT])
		else $error("undervoltage flag lost");
	chk_read_lat: assert property (!i_rd |=> rdata_ff == 8'h00)
		else $error("read data outside answer cycle");
endmodule
`default_nettype wire

// file: pkg/rrc_pkg.sv
// shared constants, types and register map of the regulator rail control block
`default_nettype none
package rrc_pkg;
	// ---------------------------------------------
	// timing
	// ---------------------------------------------
	localparam int CLK_NS        = 5;
	localparam int RAMP_STEP_NS  = 1000;
	localparam int RAMP_CYC      = (RAMP_STEP_NS + CLK_NS - 1) / CLK_NS;
	localparam int BUCK_SS_NS    = 100000;
	localparam int BUCK_SS_CYC   = (BUCK_SS_NS + CLK_NS - 1) / CLK_NS;
	localparam int SW_SS_PERIODS = 256;
	// ---------------------------------------------
	// register offsets
	// ---------------------------------------------
	localparam logic [4:0] OFS_BUCK_VOUT = 5'h00;
	localparam logic [4:0] OFS_BUCK_CFG  = 5'h01;
	localparam logic [4:0] OFS_BUCK_INT  = 5'h02;
	localparam logic [4:0] OFS_BUCK_INTM = 5'h03;
	localparam logic [4:0] OFS_BUCK_STAT = 5'h04;
	localparam logic [4:0] OFS_OPMD_ONE  = 5'h05;
	localparam logic [4:0] OFS_OPMD_TWO  = 5'h06;
	localparam logic [4:0] OFS_BUCK_FPS  = 5'h07;
	localparam logic [4:0] OFS_LIN_FPS   = 5'h08;
	localparam logic [4:0] OFS_LIN_VOUT  = 5'h09;
	localparam logic [4:0] OFS_LIN_CFG   = 5'h0A;
	localparam logic [4:0] OFS_SW_CFG0   = 5'h0B;
	localparam logic [4:0] OFS_INRUSH    = 5'h0E;
	localparam logic [4:0] OFS_SW_STAT   = 5'h0F;
	// ---------------------------------------------
	// field positions and codes
	// ---------------------------------------------
	localparam int DIS_BIT      = 0;
	localparam int FSR_BIT      = 1;
	localparam int UV_BIT       = 0;
	localparam int OV_BIT       = 1;
	localparam int SS_BIT       = 2;
	localparam int RAMP_BIT     = 3;
	localparam int AUTO_LP_BIT  = 2;
	localparam int FORCE_LP_BIT = 3;
	localparam int INR_DIS_BIT  = 0;
	localparam int THIRD_BIT    = 1;
	localparam int INR_FREQ_LSB = 2;
	localparam logic [1:0] OPMD_OFF = 2'h0;
	localparam logic [1:0] OPMD_LP  = 2'h1;
	localparam logic [1:0] FPS_NONE = 2'h3;
	localparam logic [10:0] BUCK_BASE_MV = 11'h0FA;
	localparam logic [10:0] BUCK_STEP_MV = 11'h00A;
	localparam logic [11:0] LIN_BASE_MV  = 12'h320;
	localparam logic [11:0] LIN_STEP_MV  = 12'h019;
	localparam logic [11:0] LIN_MAX_MV   = 12'hF6E;
	// ---------------------------------------------
	// reset values
	// ---------------------------------------------
	localparam logic [6:0] RST_BUCK_VOUT = 7'h50;
	localparam logic [6:0] RST_LIN_VOUT  = 7'h28;
	localparam logic [1:0] RST_MASK      = 2'h3;
	localparam logic [7:0] RST_FPS       = 8'hC0;
	localparam logic [3:0] RST_OPMD      = 4'h0;
	localparam logic       RST_LIN_ADE   = 1'b1;
	// ---------------------------------------------
	// types
	// ---------------------------------------------
	typedef enum logic [1:0] {
		RRC_OFF  = 2'b00,
		RRC_SOFT = 2'b01,
		RRC_RUN  = 2'b11
	} rrc_buck_st_t;
	typedef struct packed {
		logic       enable;
		logic [2:0] freq;
		logic [1:0] sel;
		logic       ext;
	} rrc_sw_cfg_t;
endpackage
`default_nettype wire

// file: tb/rrc_far_model.sv
// far-side model: rail comparators, supply lockout and drive oscillator
`default_nettype none
module rrc_far_model (
	input  wire logic i_uv,
	input  wire logic i_ov,
	input  wire logic i_lock,
	output logic      o_uv_cmp,
	output logic      o_ov_cmp,
	output logic      o_sys_uvlo,
	output var logic  o_drv_osc
);
	timeunit 1ns;
	timeprecision 100ps;
	// ---------------------------------------------
	// analog levels
	// ---------------------------------------------
	// comparators change with no relation to the block clock, as real ones do
	// small lag keeps level changes off the sampling edge of the block clock
	assign #1 o_uv_cmp   = i_uv;
	assign #1 o_ov_cmp   = i_ov;
	assign #1 o_sys_uvlo = i_lock;
	// ---------------------------------------------
	// drive oscillator, free running at 80 ns
	// ---------------------------------------------
	initial begin
		o_drv_osc = 1'b0;
		#13;
		forever #40 o_drv_osc = ~o_drv_osc;
	end
endmodule
`default_nettype wire

// file: tb/test_rrc_top.sv
// self-checking bench of the regulator rail control block
`default_nettype none
module test_rrc_top;
	timeunit 1ns;
	timeprecision 100ps;
	import rrc_pkg::*;
	// ---------------------------------------------
	// signals
	// ---------------------------------------------
	logic        i_clk, i_rst_n, i_wr, i_rd, i_dev_sleep, uv, ov, lock, seq;
	logic [4:0]  i_addr;
	logic [7:0]  i_wdata, o_rdata, rd_v;
	logic        uv_c, ov_c, uvlo_c, osc;
	logic [6:0]  o_buck_c_code;
	logic [10:0] o_buck_c_mv;
	logic [11:0] o_lin_mv;
	logic        o_buck_c_en, o_buck_c_lowpower, o_buck_c_discharge, o_power_down_req;
	logic        o_lin_en, o_lin_lowpower, o_lin_discharge, o_inrush_gate_drive_pin, o_inrush_pin_is_feedback;
	logic [2:0]  o_sw_gate, o_sw_done;
	logic [8:0]  o_sw_source;
	int          err_total, compares, pulses, n;
	localparam logic [4:0] RA [6]  = '{OFS_BUCK_VOUT, OFS_BUCK_INTM, OFS_BUCK_FPS, OFS_LIN_VOUT, OFS_LIN_CFG, 5'h1F};
	localparam logic [7:0] RV [6]  = '{8'h50, 8'h03, 8'hC0, 8'h28, 8'h01, 8'h00};
	localparam logic [7:0] LPM [4] = '{8'h01, 8'h0A, 8'h06, 8'h02};
	localparam logic [1:0] LPE [4] = '{2'h3, 2'h3, 2'h3, 2'h0};
	rrc_far_model far (.i_uv(uv), .i_ov(ov), .i_lock(lock), .o_uv_cmp(uv_c), .o_ov_cmp(ov_c),
		.o_sys_uvlo(uvlo_c), .o_drv_osc(osc));
	// short soft-start keeps the run brief
	rrc_top #(.SS_CYC(20)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_uv_cmp(uv_c), .i_ov_cmp(ov_c), .i_sys_uvlo(uvlo_c),
		.i_drv_osc(osc), .i_seq_buck_en(seq), .i_seq_lin_en(1'b0), .i_seq_sw_en(3'h0),
		.i_dev_sleep(i_dev_sleep), .i_inrush_drive(1'b0), .o_buck_c_code(o_buck_c_code),
		.o_buck_c_mv(o_buck_c_mv), .o_buck_c_en(o_buck_c_en), .o_buck_c_lowpower(o_buck_c_lowpower),
		.o_buck_c_discharge(o_buck_c_discharge), .o_power_down_req(o_power_down_req), .o_lin_mv(o_lin_mv),
		.o_lin_en(o_lin_en), .o_lin_lowpower(o_lin_lowpower), .o_lin_discharge(o_lin_discharge),
		.o_sw_gate(o_sw_gate), .o_sw_done(o_sw_done), .o_sw_source(o_sw_source),
		.o_inrush_gate_drive_pin(o_inrush_gate_drive_pin), .o_inrush_pin_is_feedback(o_inrush_pin_is_feedback));
	// ---------------------------------------------
	// clock, pulse counter, watchdog
	// ---------------------------------------------
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (o_power_down_req === 1'b1) pulses <= pulses + 1;
	end
	initial begin
		repeat (60000) @(posedge i_clk);
		err_total++;
		conclude();
	end
	// ---------------------------------------------
	// tasks
	// ---------------------------------------------
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %0h want %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [4:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 rd_v = o_rdata;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge i_clk);
		#1;
	endtask
	task automatic conclude;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ---------------------------------------------
	// tests
	// ---------------------------------------------
	initial begin
		{i_rst_n, i_wr, i_rd, i_dev_sleep, uv, ov, lock, seq} = 8'h00;
		i_addr = 5'h00;
		i_wdata = 8'h00;
		err_total = 0;
		compares = 0;
		pulses = 0;
		repeat (6) @(posedge i_clk);
		i_rst_n <= 1'b1;
		cyc(2);
		chk(o_buck_c_mv, 12'h41A);
		wr(5'h1F, 8'hFF);
		foreach (RA[k]) begin
			rd(RA[k]);
			chk(rd_v, RV[k]);
		end
		$display("end of reset test");
		wr(OFS_BUCK_VOUT, 8'h37);
		cyc(3);
		chk(o_buck_c_mv, 12'h320);
		chk(o_buck_c_discharge, 1'b1);
		wr(OFS_BUCK_CFG, 8'h01);
		cyc(3);
		chk(o_buck_c_discharge, 1'b0);
		wr(OFS_BUCK_CFG, 8'h00);
		wr(OFS_OPMD_ONE, 8'h02);
		uv = 1'b1;
		cyc(8);
		chk(o_buck_c_en, 1'b1);
		rd(OFS_BUCK_INT);
		chk(rd_v, 8'h00);
		rd(OFS_BUCK_STAT);
		chk(rd_v[0], 1'b1);
		uv = 1'b0;
		cyc(30);
		rd(OFS_BUCK_STAT);
		chk(rd_v, 8'h04);
		wr(OFS_BUCK_VOUT, 8'h40);
		cyc(5);
		uv = 1'b1;
		cyc(10);
		rd(OFS_BUCK_INT);
		chk(rd_v, 8'h00);
		rd(OFS_BUCK_STAT);
		chk(rd_v, 8'h0D);
		uv = 1'b0;
		cyc(2000);
		chk(o_buck_c_mv, 12'h37A);
		chk(o_buck_c_code, 12'h040);
		$display("end of buck enable and ramp test");
		wr(OFS_BUCK_INTM, 8'h02);
		n = pulses;
		uv = 1'b1;
		cyc(10);
		chk(12'(pulses - n), 12'h001);
		uv = 1'b0;
		cyc(6);
		rd(OFS_BUCK_INT);
		chk(rd_v, 8'h01);
		wr(OFS_BUCK_INT, 8'h03);
		rd(OFS_BUCK_INT);
		chk(rd_v, 8'h00);
		wr(OFS_BUCK_INTM, 8'h03);
		n = pulses;
		ov = 1'b1;
		cyc(10);
		ov = 1'b0;
		rd(OFS_BUCK_INT);
		chk(rd_v, 8'h02);
		chk(12'(pulses - n), 12'h000);
		wr(OFS_BUCK_INTM, 8'h01);
		n = pulses;
		wr(OFS_BUCK_VOUT, 8'h37);
		cyc(3);
		chk(o_buck_c_mv, 12'h320);
		ov = 1'b1;
		cyc(10);
		chk(12'(pulses - n), 12'h001);
		ov = 1'b0;
		wr(OFS_BUCK_CFG, 8'h02);
		wr(OFS_BUCK_VOUT, 8'h30);
		cyc(5);
		n = pulses;
		ov = 1'b1;
		cyc(10);
		chk(12'(pulses - n), 12'h000);
		ov = 1'b0;
		$display("end of fault test");
		wr(OFS_OPMD_TWO, 8'h02);
		wr(OFS_LIN_VOUT, 8'h7F);
		cyc(3);
		chk(o_lin_en, 1'b1);
		chk(o_lin_mv, 12'hF6E);
		wr(OFS_LIN_VOUT, 8'h00);
		cyc(3);
		chk(o_lin_mv, 12'h320);
		lock = 1'b1;
		cyc(8);
		chk({o_lin_en, o_lin_discharge}, 2'b01);
		lock = 1'b0;
		@(posedge i_clk);
		i_dev_sleep <= 1'b1;
		foreach (LPM[k]) begin
			wr(OFS_OPMD_ONE, LPM[k]);
			wr(OFS_OPMD_TWO, LPM[k]);
			cyc(3);
			chk({o_buck_c_lowpower, o_lin_lowpower}, LPE[k]);
		end
		wr(OFS_BUCK_FPS, 8'h00);
		cyc(3);
		chk(o_buck_c_en, 1'b0);
		@(posedge i_clk);
		seq <= 1'b1;
		cyc(3);
		chk(o_buck_c_en, 1'b1);
		wr(OFS_OPMD_ONE, 8'h00);
		cyc(3);
		chk(o_buck_c_en, 1'b0);
		$display("end of linear and mode test");
		wr(5'h0C, 8'h01);
		wr(OFS_INRUSH, 8'h03);
		wr(5'h0D, 8'h40);
		wr(OFS_SW_CFG0, 8'h44);
		n = 0;
		while (o_sw_done[0] !== 1'b1 && n < 6000) begin
			cyc(1);
			n++;
		end
		// one oscillator period of phase slack either way
		chk(12'(n >= 4080 && n <= 4112), 12'h001);
		chk(o_sw_source[5:0], 6'h22);
		chk(o_inrush_pin_is_feedback, 1'b1);
		cyc(3);
		chk(o_sw_done, 12'h005);
		chk(o_sw_gate, 12'h005);
		chk(o_inrush_gate_drive_pin, 1'b1);
		rd(OFS_SW_STAT);
		chk(rd_v, 8'h05);
		$display("end of switch test");
		conclude();
	end
endmodule
`default_nettype wire
